// ### hw/msmt_map.vh
`ifndef MSMT_MAP_VH
`define MSMT_MAP_VH
// ------------------------------------------------------------
// Register offsets (byte addresses on the plain port)
// ------------------------------------------------------------
`define MSMT_OFS_STBY_B    8'h00
`define MSMT_OFS_STBY_C    8'h04
`define MSMT_OFS_PWR_CTRL  8'h08
`define MSMT_OFS_WDT_CTRL  8'h0c
`define MSMT_OFS_MODE_STAT 8'h10
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MSMT_RST_STBY_B    8'hff
`define MSMT_RST_STBY_C    8'hf8
`define MSMT_RST_PWR_CTRL  8'h00
`define MSMT_RST_WDT_CTRL  8'h00
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define MSMT_STBY_C_MASK   8'hf8
`define MSMT_BIT_WDT       2
`define MSMT_BIT_SERIAL    7
`define MSMT_PC_LOW        0
`define MSMT_PC_MED        1
`define MSMT_PC_SOFTWARE_STANDBY_SELECT       2
`define MSMT_PC_TMW        3
`define MSMT_PC_DIRECT     4
`define MSMT_WD_ON         0
// ------------------------------------------------------------
// Operating modes
// ------------------------------------------------------------
`define MSMT_M_RESET       4'h0
`define MSMT_M_ACT_HI      4'h1
`define MSMT_M_ACT_MED     4'h2
`define MSMT_M_SUBACT      4'h3
`define MSMT_M_SLP_HI      4'h4
`define MSMT_M_SLP_MED     4'h5
`define MSMT_M_SUBSLP      4'h6
`define MSMT_M_STANDBY     4'h7
`define MSMT_M_WATCH       4'h8
`endif

// ### hw/msmt_sync.v
`include "msmt_map.vh"
`default_nettype none
// ------------------------------------------------------------
// Two-stage synchroniser for pin levels
// ------------------------------------------------------------
module msmt_sync (
  input  wire clk,
  input  wire reset,
  input  wire d,
  output reg  q
);
  reg meta; // First stage, read only by q
  always @(posedge clk) begin
    if (reset) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // msmt_sync
`default_nettype wire

// ### hw/msmt_top.v
// Design decisions made here: strobed register access and the placing of the registers.
`include "msmt_map.vh"
`default_nettype none
// How it works
// - Register b bits gate eight units, reset one
// - Register c bits seven..three gate units, reset one
// - Register c bits two..zero read zero always
// - Serial channel held in reset while standby
// - Watchdog standby bit stored but ignored while on
// - Clearing watchdog-on makes stored standby bit act
// - Sleep instruction enters halt chosen by flags
// - Interrupt returns halt state to execution
// - Direct active to subactive with flags 1,1,1,1
// - Direct flags 0,0,1 change active speed
// - External reset forces reset state
// - Flags 0,0,0 enter sleep, speed picks
// - Standby or watch, low-speed flag picks wake mode
module msmt_top (
  input  wire       clk,
  input  wire       reset,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire       sleep_exec,
  input  wire       irq_accept,
  input  wire       external_reset_in,
  output reg  [7:0] unit_standby_b,
  output reg  [4:0] unit_standby_c,
  output reg        serial_channel_reset,
  output reg  [3:0] op_mode,
  output reg        cpu_halted
);
  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  reg  [7:0] peripheral_standby_ctrl_b; // Bit low means unit stopped, watchdog bit only while watchdog-on is clear
  reg  [7:0] peripheral_standby_ctrl_c; // Low three bits stay zero
  reg  [4:0] pwr_ctrl;                  // Speed and transition flags
  reg        watchdog_on;               // Watchdog running flag
  wire       ext_rst_sync;              // Synchronised reset pin
  reg  [3:0] mode;                      // Current operating mode
  reg  [3:0] next_mode;                 // Mode after this cycle
  reg  [3:0] wake_mode;                 // Mode an interrupt returns to
  reg  [3:0] next_wake;                 // Wake target chosen at sleep
  wire       low_speed_select         = pwr_ctrl[`MSMT_PC_LOW];
  wire       medium_speed_select      = pwr_ctrl[`MSMT_PC_MED];
  wire       software_standby_select  = pwr_ctrl[`MSMT_PC_SOFTWARE_STANDBY_SELECT];
  wire       timer_watch_select       = pwr_ctrl[`MSMT_PC_TMW];
  wire       direct_transition_select = pwr_ctrl[`MSMT_PC_DIRECT];
  wire       executing = (mode == `MSMT_M_ACT_HI) || (mode == `MSMT_M_ACT_MED) ||
                         (mode == `MSMT_M_SUBACT);
  wire [3:0] act_speed = medium_speed_select ? `MSMT_M_ACT_MED : `MSMT_M_ACT_HI;
  // Pin is asynchronous to clk, so it crosses two flops first
  msmt_sync u_rst_sync (
    .clk   (clk),
    .reset (reset),
    .d     (external_reset_in),
    .q     (ext_rst_sync)
  );
  // ----------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      peripheral_standby_ctrl_b <= `MSMT_RST_STBY_B;
      peripheral_standby_ctrl_c <= `MSMT_RST_STBY_C;
      pwr_ctrl                  <= 5'h00;
      watchdog_on               <= 1'b0;
    end else if (wr_stb) begin
      if (addr == `MSMT_OFS_STBY_B) begin
        // Watchdog bit stores whatever is written, even while running
        peripheral_standby_ctrl_b <= wdata;
      end else if (addr == `MSMT_OFS_STBY_C) begin
        // Reserved bits masked off on every write
        peripheral_standby_ctrl_c <= wdata & `MSMT_STBY_C_MASK;
      end else if (addr == `MSMT_OFS_PWR_CTRL) begin
        pwr_ctrl <= wdata[4:0];
      end else if (addr == `MSMT_OFS_WDT_CTRL) begin
        watchdog_on <= wdata[`MSMT_WD_ON];
      end
    end
  end
  // ----------------------------------------------------------
  // Read port, data valid the cycle after the strobe
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (addr == `MSMT_OFS_STBY_B) begin
        rdata <= peripheral_standby_ctrl_b;
      end else if (addr == `MSMT_OFS_STBY_C) begin
        rdata <= peripheral_standby_ctrl_c & `MSMT_STBY_C_MASK;
      end else if (addr == `MSMT_OFS_PWR_CTRL) begin
        rdata <= {3'h0, pwr_ctrl};
      end else if (addr == `MSMT_OFS_WDT_CTRL) begin
        rdata <= {7'h00, watchdog_on};
      end else if (addr == `MSMT_OFS_MODE_STAT) begin
        rdata <= {4'h0, mode};
      end else begin
        // Unmapped addresses read zero
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end
  // ----------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------
  always @* begin
    next_mode = mode;
    next_wake = wake_mode;
    case (mode)
      `MSMT_M_RESET: begin
        // Leaves reset once the pin has gone away
        next_mode = `MSMT_M_ACT_HI;
      end
      `MSMT_M_ACT_HI, `MSMT_M_ACT_MED: begin
        if (sleep_exec) begin
          if (!low_speed_select && !software_standby_select && direct_transition_select) begin
            next_mode = act_speed;
          end else if (low_speed_select && software_standby_select && timer_watch_select &&
                       direct_transition_select) begin
            next_mode = `MSMT_M_SUBACT;
          end else if (!low_speed_select && !software_standby_select && !direct_transition_select) begin
            next_mode = medium_speed_select ? `MSMT_M_SLP_MED : `MSMT_M_SLP_HI;
            next_wake = act_speed;
          end else if (software_standby_select && !direct_transition_select &&
                       (!low_speed_select || timer_watch_select)) begin
            next_mode = timer_watch_select ? `MSMT_M_WATCH : `MSMT_M_STANDBY;
            next_wake = low_speed_select ? `MSMT_M_SUBACT : act_speed;
          end else begin
            // Undefined flag mix still yields a known halt
            next_mode = `MSMT_M_SLP_HI;
            next_wake = `MSMT_M_ACT_HI;
          end
        end
      end
      `MSMT_M_SUBACT: begin
        if (sleep_exec) begin
          if (software_standby_select && timer_watch_select && direct_transition_select) begin
            next_mode = low_speed_select ? `MSMT_M_SUBACT : act_speed;
          end else if (software_standby_select && timer_watch_select) begin
            next_mode = `MSMT_M_WATCH;
            next_wake = low_speed_select ? `MSMT_M_SUBACT : act_speed;
          end else if (low_speed_select && timer_watch_select && !direct_transition_select) begin
            next_mode = `MSMT_M_SUBSLP;
            next_wake = `MSMT_M_SUBACT;
          end else begin
            next_mode = `MSMT_M_SLP_HI;
            next_wake = `MSMT_M_ACT_HI;
          end
        end
      end
      default: begin
        // Any halt state: accepted interrupt resumes execution
        if (irq_accept) begin
          next_mode = wake_mode;
        end
      end
    endcase
  end
  // ----------------------------------------------------------
  // Mode register; reset pin overrides everything
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (reset || ext_rst_sync) begin
      mode      <= `MSMT_M_RESET;
      wake_mode <= `MSMT_M_ACT_HI;
    end else begin
      mode      <= next_mode;
      wake_mode <= next_wake;
    end
  end
  // ----------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      unit_standby_b       <= 8'h00;
      unit_standby_c       <= 5'h00;
      serial_channel_reset <= 1'b0;
      op_mode              <= `MSMT_M_RESET;
      cpu_halted           <= 1'b0;
    end else begin
      // High means unit is in standby
      unit_standby_b <= ~peripheral_standby_ctrl_b;
      // Running watchdog overrides its stored standby bit
      unit_standby_b[`MSMT_BIT_WDT] <= ~peripheral_standby_ctrl_b[`MSMT_BIT_WDT] & ~watchdog_on;
      unit_standby_c <= ~peripheral_standby_ctrl_c[7:3];
      serial_channel_reset <= ~peripheral_standby_ctrl_c[`MSMT_BIT_SERIAL];
      if (ext_rst_sync) begin
        // Pin reset must show on the mode output as well, not only inside
        op_mode    <= `MSMT_M_RESET;
        cpu_halted <= 1'b0;
      end else begin
        op_mode    <= next_mode;
        cpu_halted <= ~((next_mode == `MSMT_M_ACT_HI) || (next_mode == `MSMT_M_ACT_MED) ||
                        (next_mode == `MSMT_M_SUBACT) || (next_mode == `MSMT_M_RESET));
      end
    end
  end
  // Executing flag kept for status decode symmetry
  wire unused_exec = executing;
endmodule // msmt_top
`default_nettype wire

// ### tb/msmt_cpu.sv
`default_nettype none
// ------------------------------------------
// CPU core and interrupt side of the block
// ------------------------------------------
module msmt_cpu (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic want_sleep,
  input  wire logic want_irq,
  output var  logic sleep_exec,
  output var  logic irq_accept
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle pulses one edge after a request; never both, bench keeps them apart
  always_ff @(posedge clk) begin
    sleep_exec <= want_sleep & ~reset;
    irq_accept <= want_irq & ~reset;
  end
endmodule // msmt_cpu
`default_nettype wire

// ### tb/msmt_top_assertions.sv
`default_nettype none
// ------------------------------------------
// Port checker for the standby and mode logic
// ------------------------------------------
module msmt_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] addr,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       irq_accept,
  input wire logic       external_reset_in,
  input wire logic [7:0] unit_standby_b,
  input wire logic [4:0] unit_standby_c,
  input wire logic       serial_channel_reset,
  input wire logic [3:0] op_mode,
  input wire logic       cpu_halted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Low bits of register c never show
  property p_clow; rd_stb && addr == 8'h04 |=> rdata[2:0] == 3'h0; endproperty
  a_clow: assert property (p_clow) else $error("reserved bits read nonzero");
  // Halt flag matches the halt mode codes
  property p_halt; cpu_halted == (op_mode > 4'h3); endproperty
  a_halt: assert property (p_halt) else $error("halt flag and mode disagree");
  property p_wake; cpu_halted && irq_accept |=> !cpu_halted; endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");
  // Interrupt while executing is ignored
  property p_noirq; !cpu_halted && irq_accept && op_mode != 4'h0 |=> $stable(op_mode); endproperty
  a_noirq: assert property (p_noirq) else $error("interrupt moved running mode");
  // Pin is synchronised first, hence four cycles of margin
  property p_ext; external_reset_in [*4] |-> op_mode == 4'h0; endproperty
  a_ext: assert property (p_ext) else $error("pin reset ignored");
  property p_cchg; !$stable(unit_standby_c) |-> $past(wr_stb, 2) && $past(addr, 2) == 8'h04; endproperty
  a_cchg: assert property (p_cchg) else $error("standby c moved unasked");
  // Register b or the watchdog-on flag may move it, two edges before
  property p_bchg; !$stable(unit_standby_b) |-> $past(wr_stb, 2) &&
    ($past(addr, 2) == 8'h00 || $past(addr, 2) == 8'h0c); endproperty
  a_bchg: assert property (p_bchg) else $error("standby b moved unasked");
  property p_ser; serial_channel_reset == unit_standby_c[4]; endproperty
  a_ser: assert property (p_ser) else $error("serial reset not tied to standby");
endmodule // msmt_chk
bind msmt_top msmt_chk msmt_chk_inst (.clk(clk), .reset(reset), .addr(addr), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .irq_accept(irq_accept), .external_reset_in(external_reset_in),
  .unit_standby_b(unit_standby_b), .unit_standby_c(unit_standby_c),
  .serial_channel_reset(serial_channel_reset), .op_mode(op_mode), .cpu_halted(cpu_halted));
`default_nettype wire

// ### tb/msmt_top_tb.sv
`default_nettype none
// ------------------------------------------
// Bench for the standby and mode logic
// ------------------------------------------
module msmt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, reset, wr_stb, rd_stb, want_sleep, want_irq, external_reset_in;
  logic [7:0] addr, wdata, v;
  wire  [7:0] rdata, unit_standby_b;
  wire  [4:0] unit_standby_c;
  wire  [3:0] op_mode;
  wire        sleep_exec, irq_accept, serial_channel_reset, cpu_halted;
  int         miscompares, num_checks, i;
  // Rows: flags, mode after sleep, mode after interrupt
  localparam logic [15:0] rows [11] = '{16'h0041, 16'h0252, 16'h0471, 16'h0672, 16'h0c81,
    16'h0e82, 16'h0f83, 16'h1011, 16'h1222, 16'h1f33, 16'h0141};
  msmt_top msmt_top_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .sleep_exec(sleep_exec), .irq_accept(irq_accept),
    .external_reset_in(external_reset_in), .unit_standby_b(unit_standby_b),
    .unit_standby_c(unit_standby_c), .serial_channel_reset(serial_channel_reset),
    .op_mode(op_mode), .cpu_halted(cpu_halted));
  msmt_cpu msmt_cpu_inst (.clk(clk), .reset(reset), .want_sleep(want_sleep), .want_irq(want_irq),
    .sleep_exec(sleep_exec), .irq_accept(irq_accept));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  // Two edges: register then registered output
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic op(input logic s, input logic q);
    @(posedge clk);
    want_sleep <= s;
    want_irq <= q;
    @(posedge clk);
    want_sleep <= 1'b0;
    want_irq <= 1'b0;
    settle();
  endtask
  task automatic rst();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
  initial begin
    {reset, wr_stb, rd_stb, want_sleep, want_irq, external_reset_in} = 6'h20;
    {addr, wdata} = 16'h0000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk({4'h0, op_mode}, 8'h01);
    rd(8'h00, v);
    chk(v, 8'hff);
    rd(8'h04, v);
    chk(v, 8'hf8);
    rd(8'h20, v);
    chk(v, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, v);
    chk(v, 8'hf8);
    wr(8'h0c, 8'h01);
    wr(8'h00, 8'h00);
    settle();
    chk(unit_standby_b, 8'hfb);
    rd(8'h00, v);
    chk(v, 8'h00);
    wr(8'h0c, 8'h00);
    settle();
    chk(unit_standby_b, 8'hff);
    wr(8'h04, 8'h00);
    settle();
    chk({3'h0, unit_standby_c}, 8'h1f);
    chk({7'h0, serial_channel_reset}, 8'h01);
    @(posedge clk);
    external_reset_in <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({4'h0, op_mode}, 8'h00);
    external_reset_in <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({4'h0, op_mode}, 8'h01);
    for (i = 0; i < 11; i++) begin
      rst();
      wr(8'h08, rows[i][15:8]);
      op(1'b1, 1'b0);
      chk({4'h0, op_mode}, {4'h0, rows[i][7:4]});
      chk({7'h0, cpu_halted}, {7'h0, rows[i][7:4] > 4'h3});
      op(1'b0, 1'b1);
      chk({4'h0, op_mode}, {4'h0, rows[i][3:0]});
    end
    test_done();
  end
endmodule // msmt_top_tb
`default_nettype wire
